//--- sim/pcec_sva.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// bus and output timing checks
// ----------------------------------------------------------------
module pcec_sva
  import pcec_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic [31:0] avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic [1:0]  avs_response_out,
  input wire logic        timer_tick_in,
  input wire logic        first_output_out,
  input wire logic        second_output_out,
  input wire logic        third_output_out,
  input wire logic        fourth_output_out,
  input wire logic        fifth_output_out
);
  logic req;
  logic hit;
  // decode kept here so an unmapped hole is judged independently
  assign req = avs_read_in | avs_write_in;
  assign hit = avs_address_in inside {ADDR_CH0_RISE, ADDR_CH0_FALL, ADDR_CH1_FALL, ADDR_CH2_RISE,
                                      ADDR_CH2_FALL, ADDR_CH3_FALL, ADDR_CH4_RISE, ADDR_CH4_FALL};
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  sequence s_start; req && !$past(req); endsequence
  sequence s_done; req && !avs_waitrequest_out; endsequence
  property p_wait; s_start |-> avs_waitrequest_out; endproperty
  property p_one; s_start |=> s_done; endproperty
  property p_err; (s_done ##0 !hit) |-> avs_response_out == 2'h2; endproperty
  property p_ok; (s_done ##0 hit) |-> avs_response_out == 2'h0; endproperty
  property p_zero; (s_done ##0 avs_read_in && !hit) |-> avs_readdata_out == 32'h0; endproperty
  property p_up; (s_done ##0 avs_read_in) |-> avs_readdata_out[31:16] == 16'h0; endproperty
  property p_stand; !req |=> $stable(avs_readdata_out) && $stable(avs_response_out); endproperty
  property p_hold;
    !timer_tick_in |=> $stable({first_output_out, second_output_out, third_output_out,
                                fourth_output_out, fifth_output_out});
  endproperty
  a_wait: assert property (p_wait) else $error("no wait state on new request");
  a_one: assert property (p_one) else $error("answer not after one wait");
  a_err: assert property (p_err) else $error("unmapped access not refused");
  a_ok: assert property (p_ok) else $error("mapped access not okay");
  a_zero: assert property (p_zero) else $error("unmapped read not zero");
  a_up: assert property (p_up) else $error("upper read bits set");
  a_stand: assert property (p_stand) else $error("read data moved while idle");
  a_hold: assert property (p_hold) else $error("output moved without tick");
endmodule

bind pcec_top pcec_sva u_sva (.*);

//--- sim/pcec_tb_top.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// testbench
// ----------------------------------------------------------------
module pcec_tb_top
  import pcec_pkg::*;
();
  logic        clk_sys_in = 1'h0;
  logic        rst_in = 1'h1;
  logic [31:0] avs_address_in = '0;
  logic [31:0] avs_writedata_in = '0;
  logic [31:0] avs_readdata_out;
  logic        avs_read_in = 1'h0;
  logic        avs_write_in = 1'h0;
  logic        avs_waitrequest_out;
  logic [3:0]  avs_byteenable_in = 4'hF;
  logic [1:0]  avs_response_out;
  logic [15:0] timer_count_in = '0;
  logic        timer_tick_in = 1'h0;
  logic        compare_load_bit_in = 1'h0;
  logic        first_output_out, second_output_out, third_output_out, fourth_output_out, fifth_output_out;
  int          bad_count = 0;
  int          samples_checked = 0;
  logic [31:0] q;
  logic [1:0]  r;
  logic [4:0]  lev = '0;
  logic [15:0] cp [8] = '{default: '0};
  localparam logic [31:0] ADR [8] = '{ADDR_CH0_RISE, ADDR_CH0_FALL, ADDR_CH1_FALL, ADDR_CH2_RISE,
                                      ADDR_CH2_FALL, ADDR_CH3_FALL, ADDR_CH4_RISE, ADDR_CH4_FALL};
  // compare values kept above 1 so the load tick itself never matches
  localparam logic [15:0] DAT [8] = '{16'h5, 16'hA, 16'h8, 16'h3, 16'hC, 16'h6, 16'h7, 16'h9};
  localparam int RI [5] = '{0, 0, 3, 3, 6};
  localparam int FI [5] = '{1, 2, 4, 5, 7};
  wire [4:0] outs = {fifth_output_out, fourth_output_out, third_output_out, second_output_out, first_output_out};

  always #10 clk_sys_in = ~clk_sys_in;
  pcec_top uut (.*);

  task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t read %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_rsp(input logic [1:0] g, input logic [1:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t resp %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic [4:0] g, input logic [4:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t pins %b want %b", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk_sys_in);
    avs_read_in <= !w;
    avs_write_in <= w;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= b;
    do begin
      @(posedge clk_sys_in);
    end while (avs_waitrequest_out !== 1'h0);
    q = avs_readdata_out;
    r = avs_response_out;
    avs_read_in <= 1'h0;
    avs_write_in <= 1'h0;
  endtask

  // one timer tick; fall wins over rise on the same count
  task automatic step(input logic [15:0] c);
    @(posedge clk_sys_in);
    timer_count_in <= c;
    timer_tick_in <= 1'h1;
    @(posedge clk_sys_in);
    timer_tick_in <= 1'h0;
    for (int k = 0; k < 5; k++) begin
      if (cp[FI[k]] == c) lev[k] = 1'h0;
      else if (cp[RI[k]] == c) lev[k] = 1'h1;
    end
    #1;
    chk_pin(outs, lev);
  endtask
  task automatic run(input logic ld);
    compare_load_bit_in <= ld;
    for (int c = 0; c < 16; c++) begin
      step(c[15:0]);
      if (ld && c == 1) cp = DAT;
    end
  endtask

  initial begin
    #40000;
    bad_count++;
    test_done;
  end

  initial begin
    repeat (20) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    for (int i = 0; i < 8; i++) begin
      bus(0, ADR[i], '0, 4'hF);
      chk_rd(q, 32'h0);
    end
    for (int i = 0; i < 8; i++) bus(1, ADR[i], {16'hFFFF, DAT[i]}, 4'hF);
    for (int i = 0; i < 8; i++) begin
      bus(0, ADR[i], '0, 4'hF);
      chk_rd(q, {16'h0, DAT[i]});
      chk_rsp(r, 2'h0);
    end
    // without the load bit the old zero copies must stay in use
    run(0);
    run(1);
    run(1);
    // a later software write must not reach the copies while the load bit is clear
    bus(1, ADR[0], 32'h2, 4'hF);
    run(0);
    bus(1, 32'hFFFF0F90, 32'h1234, 4'hF);
    bus(0, 32'hFFFF0F90, '0, 4'hF);
    chk_rd(q, 32'h0);
    chk_rsp(r, 2'h2);
    bus(1, ADR[7], 32'h0000AB00, 4'h2);
    bus(0, ADR[7], '0, 4'hF);
    chk_rd(q, 32'h0000AB09);
    // leave two outputs high so the reset has something to clear
    step(16'h5);
    @(posedge clk_sys_in);
    rst_in <= 1'h1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    chk_pin(outs, 5'h0);
    bus(0, ADR[7], '0, 4'hF);
    chk_rd(q, 32'h0);
    test_done;
  end
endmodule

//--- verilog/pcec_edge_out.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// one output: set on a rise match, cleared on a fall match
// ----------------------------------------------------------------
module pcec_edge_out (
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  input  wire logic tick_in,
  input  wire logic rise_match_in,
  input  wire logic fall_match_in,
  output logic      level_out
);
  logic next_level;

  // fall wins on a tie so a zero-width pulse stays low
  always_comb begin
    next_level = level_out;
    if (tick_in && rise_match_in) begin
      next_level = 1'b1;
    end
    if (tick_in && fall_match_in) begin
      next_level = 1'b0;
    end
  end

  // level register, low out of reset
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      level_out <= 1'b0;
    end else begin
      level_out <= next_level;
    end
  end
endmodule

//--- verilog/pcec_pkg.sv
package pcec_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned NUM_REGS = 8;
  localparam logic [31:0] ADDR_CH0_RISE = 32'hFFFF0F84;
  localparam logic [31:0] ADDR_CH0_FALL = 32'hFFFF0F88;
  localparam logic [31:0] ADDR_CH1_FALL = 32'hFFFF0F8C;
  localparam logic [31:0] ADDR_CH2_RISE = 32'hFFFF0F94;
  localparam logic [31:0] ADDR_CH2_FALL = 32'hFFFF0F98;
  localparam logic [31:0] ADDR_CH3_FALL = 32'hFFFF0F9C;
  localparam logic [31:0] ADDR_CH4_RISE = 32'hFFFF0FA4;
  localparam logic [31:0] ADDR_CH4_FALL = 32'hFFFF0FA8;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;

  // register indices into the compare array
  localparam int unsigned IDX_CH0_RISE = 0;
  localparam int unsigned IDX_CH0_FALL = 1;
  localparam int unsigned IDX_CH1_FALL = 2;
  localparam int unsigned IDX_CH2_RISE = 3;
  localparam int unsigned IDX_CH2_FALL = 4;
  localparam int unsigned IDX_CH3_FALL = 5;
  localparam int unsigned IDX_CH4_RISE = 6;
  localparam int unsigned IDX_CH4_FALL = 7;

  // ----------------------------------------------------------------
  // timer values for the shadow load
  // ----------------------------------------------------------------
  localparam logic [15:0] LOAD_FROM_COUNT = 16'h0000;
  localparam logic [15:0] LOAD_TO_COUNT   = 16'h0001;

  // bus answer states
  typedef enum logic [0:0] {PCEC_IDLE, PCEC_DONE} pcec_bus_state_t;

endpackage

//--- verilog/pcec_top.sv
// Local design decision: the Avalon-MM register port.
`timescale 1ns/100ps
// Summary of operation
// - The first output goes high when the timer equals its rise compare value.
// - The first output goes low when the timer equals its fall compare value.
// - The third output goes high when the timer equals the second group's rise compare value.
// - The third output goes low when the timer equals the second group's fall compare value.
// - All compare registers reset to zero and are read/write, three in each of the first two groups and two in the third, with one unused word between groups.
// - The second output goes low when the timer equals the first group's third compare value.
// - The fourth output goes low when the timer equals the second group's third compare value.
// - With the load bit set, compare values copy to the match copies on the timer step from 0 to 1.
module pcec_top
  import pcec_pkg::*;
#(
  parameter int unsigned CMP_W = 16
) (
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  // avalon-mm slave
  input  wire logic [31:0]       avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic [31:0]            avs_readdata_out,
  output logic                   avs_waitrequest_out,
  output logic [1:0]             avs_response_out,
  // timer side
  input  wire logic [CMP_W-1:0]  timer_count_in,
  input  wire logic              timer_tick_in,
  input  wire logic              compare_load_bit_in,
  // outputs
  output logic                   first_output_out,
  output logic                   second_output_out,
  output logic                   third_output_out,
  output logic                   fourth_output_out,
  output logic                   fifth_output_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // map a byte address to a compare index; valid flag in the top bit
  function automatic logic [3:0] decode(input logic [31:0] addr);
    case (addr)
      ADDR_CH0_RISE: decode = {1'b1, 3'(IDX_CH0_RISE)};
      ADDR_CH0_FALL: decode = {1'b1, 3'(IDX_CH0_FALL)};
      ADDR_CH1_FALL: decode = {1'b1, 3'(IDX_CH1_FALL)};
      ADDR_CH2_RISE: decode = {1'b1, 3'(IDX_CH2_RISE)};
      ADDR_CH2_FALL: decode = {1'b1, 3'(IDX_CH2_FALL)};
      ADDR_CH3_FALL: decode = {1'b1, 3'(IDX_CH3_FALL)};
      ADDR_CH4_RISE: decode = {1'b1, 3'(IDX_CH4_RISE)};
      ADDR_CH4_FALL: decode = {1'b1, 3'(IDX_CH4_FALL)};
      default:       decode = 4'h0;
    endcase
  endfunction

  // merge the two low byte lanes of a write into a 16-bit value
  function automatic logic [CMP_W-1:0] merge(input logic [CMP_W-1:0] old_v,
                                             input logic [31:0]      wd,
                                             input logic [3:0]       be);
    merge = old_v;
    if (be[0]) begin
      merge[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge[CMP_W-1:8] = wd[CMP_W-1:8];
    end
  endfunction

  // ----------------------------------------------------------------
  // bus slave and software compare registers
  // ----------------------------------------------------------------
  logic [CMP_W-1:0] cmp_sw [NUM_REGS];
  logic [CMP_W-1:0] next_cmp_sw [NUM_REGS];
  pcec_bus_state_t  bus_state;
  pcec_bus_state_t  next_bus_state;
  logic [31:0]      next_readdata;
  logic [1:0]       next_response;
  logic [3:0]       dec;

  // address decode shared by read and write
  assign dec = decode(avs_address_in);
  // one wait cycle on every access, answer at the second edge
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && (bus_state == PCEC_IDLE);

  always_comb begin
    next_cmp_sw    = cmp_sw;
    next_bus_state = bus_state;
    next_readdata  = avs_readdata_out;
    next_response  = avs_response_out;
    case (bus_state)
      PCEC_IDLE: begin
        if (avs_read_in || avs_write_in) begin
          next_bus_state = PCEC_DONE;
          next_response  = dec[3] ? 2'h0 : 2'h2;   // slave error on unmapped
          next_readdata  = 32'h0;
          if (dec[3] && avs_read_in) begin
            next_readdata = 32'(cmp_sw[dec[2:0]]);
          end
        end
      end
      PCEC_DONE: begin
        next_bus_state = PCEC_IDLE;
        // commit only on the edge where waitrequest is seen low
        if (dec[3] && avs_write_in) begin
          next_cmp_sw[dec[2:0]] = merge(cmp_sw[dec[2:0]], avs_writedata_in, avs_byteenable_in);
        end
      end
      default: begin
        next_bus_state = PCEC_IDLE;
      end
    endcase
  end

  // bus state and software copies, zero out of reset
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cmp_sw[i] <= CMP_W'(COMPARE_RESET);
      end
      bus_state        <= PCEC_IDLE;
      avs_readdata_out <= 32'h0;
      avs_response_out <= 2'h0;
    end else begin
      cmp_sw           <= next_cmp_sw;
      bus_state        <= next_bus_state;
      avs_readdata_out <= next_readdata;
      avs_response_out <= next_response;
    end
  end

  // ----------------------------------------------------------------
  // internal match copies
  // ----------------------------------------------------------------
  logic [CMP_W-1:0] cmp_hw [NUM_REGS];
  logic [CMP_W-1:0] next_cmp_hw [NUM_REGS];
  logic [CMP_W-1:0] prev_count;
  logic [CMP_W-1:0] next_prev_count;
  logic             load_now;

  assign load_now = timer_tick_in && compare_load_bit_in &&
                    (prev_count == CMP_W'(LOAD_FROM_COUNT)) && (timer_count_in == CMP_W'(LOAD_TO_COUNT));

  // copies hold between loads so software can stage new edges mid-period
  always_comb begin
    next_cmp_hw     = load_now ? cmp_sw : cmp_hw;
    next_prev_count = timer_tick_in ? timer_count_in : prev_count;
  end

  // match copies and last ticked count
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cmp_hw[i] <= CMP_W'(COMPARE_RESET);
      end
      prev_count <= CMP_W'(COMPARE_RESET);
    end else begin
      cmp_hw     <= next_cmp_hw;
      prev_count <= next_prev_count;
    end
  end

  // ----------------------------------------------------------------
  // edge outputs
  // ----------------------------------------------------------------
  // first output from the first group's rise and fall pair
  pcec_edge_out u_ch0 (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .tick_in       (timer_tick_in),
    .rise_match_in (timer_count_in == cmp_hw[IDX_CH0_RISE]),
    .fall_match_in (timer_count_in == cmp_hw[IDX_CH0_FALL]),
    .level_out     (first_output_out)
  );

  pcec_edge_out u_ch1 (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .tick_in       (timer_tick_in),
    .rise_match_in (timer_count_in == cmp_hw[IDX_CH0_RISE]),
    .fall_match_in (timer_count_in == cmp_hw[IDX_CH1_FALL]),
    .level_out     (second_output_out)
  );

  pcec_edge_out u_ch2 (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .tick_in       (timer_tick_in),
    .rise_match_in (timer_count_in == cmp_hw[IDX_CH2_RISE]),
    .fall_match_in (timer_count_in == cmp_hw[IDX_CH2_FALL]),
    .level_out     (third_output_out)
  );

  pcec_edge_out u_ch3 (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .tick_in       (timer_tick_in),
    .rise_match_in (timer_count_in == cmp_hw[IDX_CH2_RISE]),
    .fall_match_in (timer_count_in == cmp_hw[IDX_CH3_FALL]),
    .level_out     (fourth_output_out)
  );

  // fifth output from the third group's pair
  pcec_edge_out u_ch4 (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .tick_in       (timer_tick_in),
    .rise_match_in (timer_count_in == cmp_hw[IDX_CH4_RISE]),
    .fall_match_in (timer_count_in == cmp_hw[IDX_CH4_FALL]),
    .level_out     (fifth_output_out)
  );

endmodule
